// file: common/rucf_pkg.sv
/*
 * rucf_pkg: constants, codes and carriers for the receive unit control fsm.
 * assumes one 100 MHz clock domain shared by every user of the package.
 */
`default_nettype none
package rucf_pkg;

   // status word layout
   localparam int          STATUS_W        = 16;
   localparam int          STATE_LSB       = 2;
   localparam int          STATE_MSB       = 5;
   localparam int          FR_PEND_BIT     = 14;
   localparam int          RNR_PEND_BIT    = 12;
   localparam logic [15:0] STATUS_RESET    = 16'h0000;

   // receive state codes as reported in the status word
   localparam logic [3:0]  CODE_IDLE       = 4'h0;
   localparam logic [3:0]  CODE_SUSPENDED  = 4'h1;
   localparam logic [3:0]  CODE_NO_DESC    = 4'h2;
   localparam logic [3:0]  CODE_READY      = 4'h4;

   // pointers and reset values
   localparam int          PTR_W           = 32;
   localparam logic [31:0] PTR_RESET       = 32'h0000_0000;
   localparam logic [1:0]  PEND_RESET      = 2'h0;

   // pending interrupt bit positions in the ack and pending vectors
   localparam int          PEND_FRAME      = 0;
   localparam int          PEND_STOPPED    = 1;
   localparam int          PEND_N          = 2;

   // receive unit control field of the command byte
   typedef enum logic [2:0] {
      RUCF_CMD_NOP      = 3'h0,
      RUCF_CMD_BEGIN    = 3'h1,
      RUCF_CMD_CONTINUE = 3'h2,
      RUCF_CMD_HALT     = 3'h4,
      RUCF_CMD_HDR_LOAD = 3'h5
   } rucf_cmd_e;

   typedef enum logic [3:0] {
      RUCF_ST_IDLE  = 4'b0001,
      RUCF_ST_SUSP  = 4'b0010,
      RUCF_ST_NODSC = 4'b0100,
      RUCF_ST_READY = 4'b1000
   } rucf_state_e;

   // command byte and general pointer as seen at acceptance
   typedef struct packed {
      logic             pending;
      rucf_cmd_e        code;
      logic [31:0]      area_offset;
   } rucf_cmd_s;

   // events from the receive datapath and descriptor engine
   typedef struct packed {
      logic             arriving;
      logic             frame_end;
      logic             desc_done;
      logic             end_of_list_bit;
      logic             halt_after_marker;
      logic             data_in_desc;
   } rucf_rx_s;

   // one-cycle requests to the dma and descriptor logic
   typedef struct packed {
      logic             setup_desc;
      logic             release_prefetch;
      logic             abort_dma;
      logic             discard_count;
   } rucf_act_s;

   function automatic logic [3:0] rucf_code(rucf_state_e s);
      case (s)
         RUCF_ST_SUSP:  rucf_code = CODE_SUSPENDED;
         RUCF_ST_NODSC: rucf_code = CODE_NO_DESC;
         RUCF_ST_READY: rucf_code = CODE_READY;
         default:       rucf_code = CODE_IDLE;
      endcase
   endfunction

endpackage
`default_nettype wire

// file: hw/rucf_flag.sv
/*
 * rucf_flag: sticky flag, set wins over clear in the same cycle.
 * assumes set and clear are single-cycle terms on the module clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rucf_flag (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic set,
   input  wire logic clear,
   output logic      flag
);
   import rucf_pkg::*;

   logic flag_reg;
   logic flag_next;

   // a late event must not be lost under a concurrent clear
   always_comb begin
      flag_next = flag_reg;
      if (clear) begin
         flag_next = 1'b0;
      end
      if (set) begin
         flag_next = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         flag_reg <= 1'b0;
      end else begin
         flag_reg <= flag_next;
      end
   end

   assign flag = flag_reg;
endmodule // rucf_flag
`default_nettype wire

// file: hw/rucf_accept.sv
/*
 * rucf_accept: command acceptance gate for the receive unit.
 * assumes the command byte stays pending until the clear pulse is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module rucf_accept (
   input  wire logic clock,
   input  wire logic rstn,
   input  wire logic cmd_pending,
   input  wire logic cu_accept_done,
   output logic      accept,
   output logic      cmd_clear
);
   import rucf_pkg::*;

   logic busy_reg;
   logic busy_next;
   logic clear_reg;
   logic clear_next;

   // wait for the command unit, then one acceptance per written command
   always_comb begin
      accept     = cmd_pending & cu_accept_done & ~busy_reg;
      clear_next = accept;
      busy_next  = busy_reg;
      if (accept) begin
         busy_next = 1'b1;
      end else if (!cmd_pending && !clear_reg) begin
         busy_next = 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         busy_reg  <= 1'b0;
         clear_reg <= 1'b0;
      end else begin
         busy_reg  <= busy_next;
         clear_reg <= clear_next;
      end
   end

   assign cmd_clear = clear_reg;
endmodule // rucf_accept
`default_nettype wire

// file: hw/rucf_top.sv
/*
 * rucf_top: receive unit control state machine of a 10/100 ethernet mac.
 * assumes command byte, descriptor events and frame activity come from
 * logic on the same clock; host memory writes happen outside this block.
 */
`timescale 1ns/1ps
`default_nettype none
module rucf_top (
   input  wire logic                      clock,
   input  wire logic                      rstn,
   input  wire rucf_pkg::rucf_cmd_s       cmd,
   input  wire logic                      cu_accept_done,
   input  wire logic                      cu_flag_done,
   input  wire logic                      cu_state_change,
   input  wire rucf_pkg::rucf_rx_s        rx,
   input  wire logic [1:0]                irq_ack,
   output logic                           cmd_clear,
   output logic [15:0]                    status_word,
   output logic                           status_write,
   output logic [31:0]                    next_desc_ptr,
   output logic                           storing,
   output logic                           discarding,
   output rucf_pkg::rucf_act_s            act,
   output logic                           host_interrupt_line
);
   import rucf_pkg::*;

   rucf_state_e state_reg;
   rucf_state_e state_next;
   logic [31:0] ptr_reg;
   logic [31:0] ptr_next;
   logic [15:0] status_reg;
   logic [15:0] status_next;
   logic        stwr_reg;
   logic        stwr_next;
   logic        upd_reg;
   logic        upd_next;
   rucf_act_s   act_reg;
   rucf_act_s   act_next;

   logic        accept;
   logic        begin_flag;
   logic        cont_flag;
   logic        begin_set;
   logic        begin_clr;
   logic        cont_set;
   logic        cont_clr;
   logic [1:0]  pend;
   logic [1:0]  pend_set;
   logic        receiving;
   logic        is_begin;
   logic        is_cont;
   logic        is_halt;

   rucf_accept u_accept (
      .clock          (clock),
      .rstn           (rstn),
      .cmd_pending    (cmd.pending),
      .cu_accept_done (cu_accept_done),
      .accept         (accept),
      .cmd_clear      (cmd_clear)
   );

   // deferred begin and continue requests, acted on at end of frame
   rucf_flag u_begin_flag (
      .clock (clock),
      .rstn  (rstn),
      .set   (begin_set),
      .clear (begin_clr),
      .flag  (begin_flag)
   );

   rucf_flag u_cont_flag (
      .clock (clock),
      .rstn  (rstn),
      .set   (cont_set),
      .clear (cont_clr),
      .flag  (cont_flag)
   );

   // pending interrupt bits, acknowledged by software writes
   genvar g;
   generate
      for (g = 0; g < PEND_N; g = g + 1) begin : g_pend
         rucf_flag u_pend (
            .clock (clock),
            .rstn  (rstn),
            .set   (pend_set[g]),
            .clear (irq_ack[g]),
            .flag  (pend[g])
         );
      end
   endgenerate

   // line drops as soon as every pending bit is acknowledged
   assign host_interrupt_line = |pend;

   always_comb begin
      receiving  = rx.arriving;
      is_begin   = accept && (cmd.code == RUCF_CMD_BEGIN);
      is_cont    = accept && (cmd.code == RUCF_CMD_CONTINUE);
      is_halt    = accept && (cmd.code == RUCF_CMD_HALT);
      state_next = state_reg;
      ptr_next   = ptr_reg;
      act_next   = '0;
      begin_set  = 1'b0;
      begin_clr  = 1'b0;
      cont_set   = 1'b0;
      cont_clr   = 1'b0;
      pend_set   = 2'b00;

      // frame completion: the point where deferred requests take effect
      if (rx.frame_end) begin
         if (state_reg == RUCF_ST_READY) begin
            pend_set[PEND_FRAME] = 1'b1;
         end
         if (state_reg == RUCF_ST_NODSC) begin
            act_next.discard_count = 1'b1;
         end
         if (begin_flag) begin
            state_next          = RUCF_ST_READY;
            act_next.setup_desc = 1'b1;
            begin_clr           = 1'b1;
            cont_clr            = 1'b1;
         end else if (cont_flag && state_reg == RUCF_ST_SUSP) begin
            state_next          = RUCF_ST_READY;
            act_next.setup_desc = 1'b1;
            cont_clr            = 1'b1;
         end else if (cont_flag) begin
            cont_clr = 1'b1;
         end
      end

      // descriptor consumed while storing; end of list outranks halt
      if (rx.desc_done && state_reg == RUCF_ST_READY) begin
         if (rx.end_of_list_bit) begin
            state_next = RUCF_ST_NODSC;
         end else if (rx.halt_after_marker) begin
            state_next = RUCF_ST_SUSP;
         end
      end

      // commands at acceptance; a halt overrides frame-end state and action pulses, but not the frame interrupt
      if (is_halt) begin
         if (state_reg == RUCF_ST_READY) begin
            pend_set[PEND_STOPPED] = 1'b1;
         end
         state_next = RUCF_ST_IDLE;
         act_next   = '0;
         act_next.abort_dma = 1'b1;
         begin_clr  = 1'b1;
         cont_clr   = 1'b1;
         begin_set  = 1'b0;
      end else if (is_begin) begin
         ptr_next = cmd.area_offset;
         if (receiving) begin
            begin_set = 1'b1;
         end else begin
            begin_clr = 1'b1;
            if (state_reg != RUCF_ST_READY && !rx.data_in_desc) begin
               state_next                = RUCF_ST_READY;
               act_next.release_prefetch = 1'b1;
               act_next.setup_desc       = 1'b1;
            end
         end
      end else if (is_cont) begin
         if (state_reg == RUCF_ST_SUSP) begin
            if (receiving) begin
               cont_set = 1'b1;
            end else begin
               state_next          = RUCF_ST_READY;
               act_next.setup_desc = 1'b1;
            end
         end
         // any other state: nothing happens
      end
   end

   // status write is held back one cycle behind the command clear, so
   // software sees the byte clear first and the new status after it
   always_comb begin
      upd_next = accept
               | (state_next != state_reg)
               | rx.frame_end
               | cu_flag_done
               | cu_state_change
               | (|pend_set);
      stwr_next   = upd_reg;
      status_next = status_reg;
      if (upd_reg) begin
         status_next                     = STATUS_RESET;
         status_next[STATE_MSB:STATE_LSB] = rucf_code(state_reg);
         status_next[FR_PEND_BIT]        = pend[PEND_FRAME];
         status_next[RNR_PEND_BIT]       = pend[PEND_STOPPED];
      end
   end

   // state group: state, pointer and action pulses
   always_ff @(posedge clock) begin
      if (!rstn) begin
         state_reg  <= RUCF_ST_IDLE;
         ptr_reg    <= PTR_RESET;
         act_reg    <= '0;
      end else begin
         state_reg  <= state_next;
         ptr_reg    <= ptr_next;
         act_reg    <= act_next;
      end
   end

   // status group: word, write strobe and its one-cycle lag
   always_ff @(posedge clock) begin
      if (!rstn) begin
         status_reg <= STATUS_RESET;
         stwr_reg   <= 1'b0;
         upd_reg    <= 1'b0;
      end else begin
         status_reg <= status_next;
         stwr_reg   <= stwr_next;
         upd_reg    <= upd_next;
      end
   end

   // only ready stores; idle, suspended and no-descriptors all discard
   assign storing       = (state_reg == RUCF_ST_READY);
   assign discarding    = ~storing;
   assign status_word   = status_reg;
   assign status_write  = stwr_reg;
   assign next_desc_ptr = ptr_reg;
   assign act           = act_reg;
endmodule // rucf_top
`default_nettype wire

// file: dv/rucf_host.sv
/* rucf_host: host side model, holds the command byte written by software.
   assumes one write pulse per command, on the design clock. */
`timescale 1ns/1ps
`default_nettype none
module rucf_host (
   input  wire logic               clock,
   input  wire logic               rstn,
   input  wire logic               wr,
   input  wire rucf_pkg::rucf_cmd_e wr_code,
   input  wire logic [31:0]        wr_off,
   input  wire logic               cmd_clear,
   output var rucf_pkg::rucf_cmd_s  cmd
);
   import rucf_pkg::*;
   rucf_cmd_s cmd_reg;
   rucf_cmd_s cmd_next;
   always_comb begin
      cmd_next = cmd_reg;
      if (cmd_clear) begin
         cmd_next.pending = 1'b0; // byte cleared by the device
         cmd_next.area_offset = ~cmd_reg.area_offset; // released pointer must not look valid
      end
      if (wr)
         cmd_next = '{1'b1, wr_code, wr_off}; // one unit command per write
   end
   always_ff @(posedge clock) begin
      if (!rstn)
         cmd_reg <= '0;
      else
         cmd_reg <= cmd_next;
   end
   assign cmd = cmd_reg;
endmodule // rucf_host
`default_nettype wire

// file: dv/rucf_top_props.sv
/* rucf_top_props: port level checks of the receive unit control fsm.
   assumes the single clock domain and synchronous active low reset. */
`timescale 1ns/1ps
`default_nettype none
module rucf_top_props (
   input  wire logic                clock,
   input  wire logic                rstn,
   input  wire rucf_pkg::rucf_cmd_s cmd,
   input  wire rucf_pkg::rucf_rx_s  rx,
   input  wire logic [1:0]          irq_ack,
   input  wire logic                cmd_clear,
   input  wire logic [15:0]         status_word,
   input  wire logic                status_write,
   input  wire logic [31:0]         next_desc_ptr,
   input  wire logic                storing,
   input  wire rucf_pkg::rucf_act_s act,
   input  wire logic                host_interrupt_line
);
   import rucf_pkg::*;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);
   property p_clr_status; cmd_clear |=> status_write; endproperty
   property p_rose_ready; $rose(storing) |=> status_word[5:2] == CODE_READY; endproperty
   property p_halt;
      cmd_clear && $past(cmd.code) == RUCF_CMD_HALT |-> !storing && (!$past(storing) || act.abort_dma && host_interrupt_line);
   endproperty
   property p_begin_ptr; cmd_clear && $past(cmd.code) == RUCF_CMD_BEGIN |-> next_desc_ptr == $past(cmd.area_offset); endproperty
   property p_begin_state;
      cmd_clear && $past(cmd.code) == RUCF_CMD_BEGIN && !$past(rx.data_in_desc) |-> storing == !$past(rx.arriving);
   endproperty
   property p_cont_idle; cmd_clear && $past(cmd.code) == RUCF_CMD_CONTINUE && $past(status_word[5:2]) == CODE_IDLE |-> !storing; endproperty
   property p_cont_susp;
      cmd_clear && $past(cmd.code) == RUCF_CMD_CONTINUE && $past(status_word[5:2]) == CODE_SUSPENDED && !$past(rx.arriving) |-> storing;
   endproperty
   property p_frame_irq; rx.frame_end && storing |=> host_interrupt_line; endproperty
   property p_ack; irq_ack == 2'h3 && !rx.frame_end && !cmd.pending |=> !host_interrupt_line; endproperty
   property p_eol; storing && rx.desc_done && rx.end_of_list_bit |=> !storing ##1 status_word[5:2] == CODE_NO_DESC; endproperty
   property p_marker;
      storing && rx.desc_done && !rx.end_of_list_bit && rx.halt_after_marker |=> ##1 status_word[5:2] == CODE_SUSPENDED;
   endproperty
   a_clr_status: assert property (p_clr_status)
      else $error("no status write after command clear");
   a_rose_ready: assert property (p_rose_ready)
      else $error("ready code missing from status");
   a_halt: assert property (p_halt)
      else $error("halt did not stop reception");
   a_begin_ptr: assert property (p_begin_ptr)
      else $error("descriptor pointer not loaded");
   a_begin_state: assert property (p_begin_state)
      else $error("begin state wrong for activity");
   a_cont_idle: assert property (p_cont_idle)
      else $error("continue not ignored");
   a_cont_susp: assert property (p_cont_susp)
      else $error("continue did not resume");
   a_frame_irq: assert property (p_frame_irq)
      else $error("no interrupt after frame");
   a_ack: assert property (p_ack)
      else $error("interrupt line held after ack");
   a_eol: assert property (p_eol)
      else $error("end of list not handled");
   a_marker: assert property (p_marker)
      else $error("halt marker not handled");
   c_abort: cover property (act.abort_dma);
   c_frame: cover property (rx.frame_end && storing);
   c_defer: cover property (cmd_clear && rx.arriving);
endmodule // rucf_top_props
bind rucf_top rucf_top_props u_props (.clock, .rstn, .cmd, .rx, .irq_ack, .cmd_clear, .status_word, .status_write,
   .next_desc_ptr, .storing, .act, .host_interrupt_line);
`default_nettype wire

// file: dv/testbench.sv
/* testbench: command sequences against the receive unit control fsm.
   assumes rucf_host holds the command byte; inputs change at falling edges. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rucf_pkg::*;
   logic        clock, rstn, wr, cu_accept_done, cu_flag_done, cu_state_change;
   logic        cmd_clear, status_write, storing, discarding, host_interrupt_line;
   rucf_cmd_e   wr_code;
   logic [31:0] wr_off, next_desc_ptr;
   logic [1:0]  irq_ack;
   logic [15:0] status_word;
   rucf_cmd_s   cmd;
   rucf_rx_s    rx;
   rucf_act_s   act;
   int          n_errors = 0;
   int          samples_checked = 0;
   bit          got;
   rucf_act_s   act_seen;
   rucf_host u_host (.clock(clock), .rstn(rstn), .wr(wr), .wr_code(wr_code), .wr_off(wr_off),
      .cmd_clear(cmd_clear), .cmd(cmd));
   rucf_top u_dut (.clock(clock), .rstn(rstn), .cmd(cmd), .cu_accept_done(cu_accept_done),
      .cu_flag_done(cu_flag_done), .cu_state_change(cu_state_change), .rx(rx), .irq_ack(irq_ack),
      .cmd_clear(cmd_clear), .status_word(status_word), .status_write(status_write),
      .next_desc_ptr(next_desc_ptr), .storing(storing), .discarding(discarding), .act(act),
      .host_interrupt_line(host_interrupt_line));
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic close_out;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask
   // bounded wait, a lost clear must not hang the run
   task automatic wclr(output bit g);
      g = 1'b0;
      act_seen = '0;
      for (int i = 0; i < 10 && !g; i++) begin
         tick(1);
         g = cmd_clear;
         // action pulses stand in the same cycle as the clear
         if (g)
            act_seen = act;
      end
      tick(3);
   endtask
   task automatic cmd_w(input rucf_cmd_e c, input logic [31:0] o, output bit g);
      wr = 1'b1;
      wr_code = c;
      wr_off = o;
      tick(1);
      wr = 1'b0;
      wclr(g);
   endtask
   // one cycle of datapath events; frame activity ends with it
   task automatic rxp(input logic fe, input logic dd, input logic eol, input logic hm);
      rx.frame_end = fe;
      rx.desc_done = dd;
      rx.end_of_list_bit = eol;
      rx.halt_after_marker = hm;
      tick(1);
      act_seen = act;
      rx = '0;
      tick(3);
   endtask
   task automatic ack(input logic [1:0] a);
      irq_ack = a;
      tick(1);
      irq_ack = 2'h0;
      tick(2);
   endtask
   task automatic sw_wait(output bit g);
      g = 1'b0;
      repeat (4) begin
         tick(1);
         if (status_write === 1'b1)
            g = 1'b1;
      end
   endtask
   initial begin
      #20000;
      n_errors++;
      close_out();
   end
   initial begin
      rstn = 1'b0;
      wr = 1'b0;
      wr_code = RUCF_CMD_NOP;
      wr_off = 32'h0;
      cu_accept_done = 1'b1;
      cu_flag_done = 1'b0;
      cu_state_change = 1'b0;
      rx = '0;
      irq_ack = 2'h0;
      tick(3);
      rstn = 1'b1;
      tick(1);
      chk(status_word, STATUS_RESET);
      chk(discarding, 1'b1);
      chk(next_desc_ptr, PTR_RESET);
      cmd_w(RUCF_CMD_CONTINUE, 32'h0, got);
      chk(status_word[5:2], CODE_IDLE);
      cu_accept_done = 1'b0;
      cmd_w(RUCF_CMD_BEGIN, 32'h0000_1000, got);
      chk(got, 1'b0);
      cu_accept_done = 1'b1;
      wclr(got);
      chk(got, 1'b1);
      chk(status_word[5:2], CODE_READY);
      chk(next_desc_ptr, 32'h0000_1000);
      chk(storing, 1'b1);
      chk(act_seen.setup_desc, 1'b1);
      chk(act_seen.release_prefetch, 1'b1);
      rx.arriving = 1'b1;
      tick(2);
      rxp(1'b1, 1'b0, 1'b0, 1'b0);
      chk(host_interrupt_line, 1'b1);
      chk(status_word[FR_PEND_BIT], 1'b1);
      ack(2'h1);
      chk(host_interrupt_line, 1'b0);
      rxp(1'b0, 1'b1, 1'b0, 1'b1);
      chk(status_word[5:2], CODE_SUSPENDED);
      cmd_w(RUCF_CMD_CONTINUE, 32'h0, got);
      chk(status_word[5:2], CODE_READY);
      chk(act_seen.setup_desc, 1'b1);
      rxp(1'b0, 1'b1, 1'b0, 1'b1);
      rx.arriving = 1'b1;
      cmd_w(RUCF_CMD_CONTINUE, 32'h0, got);
      chk(status_word[5:2], CODE_SUSPENDED);
      chk(act_seen.setup_desc, 1'b0);
      rxp(1'b1, 1'b0, 1'b0, 1'b0);
      chk(status_word[5:2], CODE_READY);
      chk(act_seen.setup_desc, 1'b1);
      rxp(1'b0, 1'b1, 1'b1, 1'b0);
      chk(status_word[5:2], CODE_NO_DESC);
      chk(discarding, 1'b1);
      rx.arriving = 1'b1;
      // begin during a frame in no-descriptors: pointer loads now, ready at frame end
      cmd_w(RUCF_CMD_BEGIN, 32'h0000_2000, got);
      chk(status_word[5:2], CODE_NO_DESC);
      chk(next_desc_ptr, 32'h0000_2000);
      chk(act_seen.setup_desc, 1'b0);
      rxp(1'b1, 1'b0, 1'b0, 1'b0);
      chk(status_word[5:2], CODE_READY);
      chk(act_seen.setup_desc, 1'b1);
      chk(act_seen.discard_count, 1'b1);
      ack(2'h3);
      cmd_w(RUCF_CMD_HALT, 32'h0, got);
      chk(status_word[5:2], CODE_IDLE);
      chk(act_seen.abort_dma, 1'b1);
      chk(status_word[RNR_PEND_BIT], 1'b1);
      ack(2'h3);
      chk(host_interrupt_line, 1'b0);
      cmd_w(RUCF_CMD_HALT, 32'h0, got);
      chk(host_interrupt_line, 1'b0);
      // data already in the descriptor: pointer loads, state holds
      rx.data_in_desc = 1'b1;
      cmd_w(RUCF_CMD_BEGIN, 32'h0000_3000, got);
      chk(status_word[5:2], CODE_IDLE);
      chk(next_desc_ptr, 32'h0000_3000);
      chk(act_seen.setup_desc, 1'b0);
      rx.data_in_desc = 1'b0;
      cmd_w(RUCF_CMD_HDR_LOAD, 32'h0, got);
      chk(got, 1'b1);
      cu_flag_done = 1'b1;
      tick(1);
      cu_flag_done = 1'b0;
      sw_wait(got);
      chk(got, 1'b1);
      cu_state_change = 1'b1;
      tick(1);
      cu_state_change = 1'b0;
      sw_wait(got);
      chk(got, 1'b1);
      close_out();
   end
endmodule // testbench
`default_nettype wire
